// ==== inc/lsfs_pkg.sv ====
package lsfs_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] LSFS_CTRL_OFS = 8'h00;
    localparam logic [7:0] LSFS_NUM_OFS = 8'h04;
    localparam logic [7:0] LSFS_DEN_OFS = 8'h08;
    localparam logic [7:0] LSFS_FILT_OFS = 8'h0C;
    localparam logic [7:0] LSFS_RES_OFS = 8'h10;
    localparam logic [7:0] LSFS_STAT_OFS = 8'h14;
    localparam logic [7:0] LSFS_IRQ_STAT_OFS = 8'h18;
    localparam logic [7:0] LSFS_IRQ_MASK_OFS = 8'h1C;
    localparam logic [7:0] LSFS_MOTOR_CUM_OFS = 8'h20;
    localparam logic [7:0] LSFS_SCALED_CUM_OFS = 8'h24;
    localparam logic [7:0] LSFS_LOAD_CUM_OFS = 8'h28;
    localparam logic [7:0] LSFS_LOAD_POS_OFS = 8'h2C;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int LSFS_CTRL_POL_BIT = 0;
    localparam int LSFS_CTRL_ABZ_ROT_BIT = 1;
    localparam int LSFS_CTRL_W = 2;
    localparam int LSFS_ST_ALARM_BIT = 0;
    localparam int LSFS_ST_FULL_BIT = 1;
    localparam int LSFS_ST_DUAL_BIT = 2;
    localparam int LSFS_ST_ROTARY_BIT = 3;
    localparam int LSFS_ST_BUSY_BIT = 4;
    localparam int LSFS_IRQ_ALARM_BIT = 0;
    localparam int LSFS_IRQ_ZMARK_BIT = 1;
    localparam int LSFS_IRQ_CHECK_BIT = 2;
    localparam int LSFS_IRQ_W = 3;
    localparam int LSFS_FILT_W = 13;

    // ----------------------------------------------------------------
    // reset values and limits
    // ----------------------------------------------------------------
    localparam logic [1:0] LSFS_CTRL_RESET = 2'h0;
    localparam logic [31:0] LSFS_GEAR_RESET = 32'h0000_0001;
    localparam logic [31:0] LSFS_RES_RESET = 32'h0000_0000;
    localparam logic [12:0] LSFS_FILT_RESET = 13'h000A;
    localparam logic [12:0] LSFS_FILT_DUAL_MIN = 13'h0001;
    localparam logic [12:0] LSFS_FILT_DUAL_MAX = 13'h1193;
    localparam logic [12:0] LSFS_FILT_FULL = 13'h1194;
    localparam logic [31:0] LSFS_GEAR_LIMIT = 32'h7FFF_FFFF;
    // weight = filter * 932 / 2^22, close to filter / 4500
    localparam logic [9:0] LSFS_BLEND_RECIP = 10'h3A4;
    localparam int LSFS_BLEND_SHIFT = 22;

    typedef enum logic [1:0] {
        LSFS_IDLE = 2'b00,
        LSFS_RUN = 2'b01,
        LSFS_DONE = 2'b11
    } lsfs_gcd_state_t;

endpackage

// ==== rtl/lsfs_gcd_check.sv ====
`timescale 1ns/1ps
module lsfs_gcd_check
    import lsfs_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // request
    input wire logic i_start,
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    // result
    output logic o_busy,
    output logic o_done,
    output logic o_coprime
);
    // binary gcd: only tells whether gcd(a,b) is one
    lsfs_gcd_state_t state_q;
    logic [W-1:0] a_q;
    logic [W-1:0] b_q;
    logic coprime_q;

    wire a_zero = (a_q == '0);
    wire b_zero = (b_q == '0);
    wire both_even = !a_q[0] && !b_q[0];
    wire finish = a_zero || b_zero || both_even || (a_q == b_q);
    wire result = a_zero ? (b_q == W'(1)) : b_zero ? (a_q == W'(1)) :
                  both_even ? 1'b0 : (a_q == W'(1));

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state_q <= LSFS_IDLE;
            a_q <= '0;
            b_q <= '0;
            coprime_q <= 1'b0;
        end else begin
            case (state_q)
                LSFS_IDLE: begin
                    if (i_start) begin
                        a_q <= i_a;
                        b_q <= i_b;
                        state_q <= LSFS_RUN;
                    end
                end
                LSFS_RUN: begin
                    if (finish) begin
                        coprime_q <= result;
                        state_q <= LSFS_DONE;
                    end else if (!a_q[0]) begin
                        a_q <= a_q >> 1;
                    end else if (!b_q[0]) begin
                        b_q <= b_q >> 1;
                    end else if (a_q > b_q) begin
                        a_q <= a_q - b_q;
                    end else begin
                        b_q <= b_q - a_q;
                    end
                end
                default: begin
                    state_q <= LSFS_IDLE;
                end
            endcase
        end
    end

    assign o_busy = (state_q != LSFS_IDLE);
    assign o_done = (state_q == LSFS_DONE);
    assign o_coprime = coprime_q;

endmodule

// ==== rtl/lsfs_feedback.sv ====
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// (R1) reduced gear term above limit raises alarm
// (R2) abz rotary with zero resolution skips check
// (R3) filter 1..4499 dual, 4500 fully closed
// (R4) filter setting resets to ten
// (R5) larger filter weights load feedback more
// (R6) software keeps filter below half loop gain
// (R7) abz resolution zero linear, nonzero rotary
// (R8) reference mark clears load position information
// (R9) load pulses accumulate into cumulative counter
// (R10) scaled motor and load counts track equally
// (R11) raw motor cumulative count is kept
// (R12) polarity one inverts load count direction
// (R13) load encoder gives 4096..67108864 pulses/rev
// (R14) scaler multiplies, divides, carries remainder forward
module lsfs_feedback
    import lsfs_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // motor encoder pulses (pins)
    input wire logic i_motor_step,
    input wire logic i_motor_dir,
    // load encoder a/b/z (pins)
    input wire logic i_load_a,
    input wire logic i_load_b,
    input wire logic i_load_z,
    // feedback and status
    output logic [31:0] o_fb_position,
    output logic o_fully_closed,
    output logic o_dual_feedback,
    output logic o_load_rotary,
    output logic o_param_alarm,
    output logic o_irq
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_prev_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_prev_q <= 5'h00;
        end else begin
            pin_s1_q <= {i_motor_step, i_motor_dir, i_load_a, i_load_b, i_load_z};
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    wire motor_edge = pin_s2_q[4] && !pin_prev_q[4];
    wire motor_ccw = pin_s2_q[3];
    wire a_now = pin_s2_q[2];
    wire b_now = pin_s2_q[1];
    wire a_old = pin_prev_q[2];
    wire b_old = pin_prev_q[1];
    wire z_edge = pin_s2_q[0] && !pin_prev_q[0];
    // exactly one of a/b moved; a double change is a lost state and is dropped
    wire load_step = (a_now ^ a_old) ^ (b_now ^ b_old);
    wire load_fwd = a_now ^ b_old;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [31:0] num_q;
    logic [31:0] den_q;
    logic [12:0] filt_q;
    logic [31:0] res_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic check_start_q;
    logic chk_busy;
    logic chk_done;
    logic chk_coprime;
    logic hreadyout_q;
    logic [31:0] hrdata_q;

    wire addr_valid = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'h2);
    wire [7:0] addr_lo = i_haddr[7:0];
    wire wr_ctrl = wr_pend_q && (wr_addr_q == LSFS_CTRL_OFS);
    wire wr_num = wr_pend_q && (wr_addr_q == LSFS_NUM_OFS);
    wire wr_den = wr_pend_q && (wr_addr_q == LSFS_DEN_OFS);
    wire wr_filt = wr_pend_q && (wr_addr_q == LSFS_FILT_OFS);
    wire wr_res = wr_pend_q && (wr_addr_q == LSFS_RES_OFS);
    wire wr_irq_stat = wr_pend_q && (wr_addr_q == LSFS_IRQ_STAT_OFS);
    wire wr_irq_mask = wr_pend_q && (wr_addr_q == LSFS_IRQ_MASK_OFS);

    wire polarity_inv = ctrl_q[LSFS_CTRL_POL_BIT];
    wire abz_rotary = ctrl_q[LSFS_CTRL_ABZ_ROT_BIT];

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_q <= LSFS_CTRL_RESET;
            num_q <= LSFS_GEAR_RESET;
            den_q <= LSFS_GEAR_RESET;
            filt_q <= LSFS_FILT_RESET; // R4
            res_q <= LSFS_RES_RESET;
            irq_mask_q <= 3'h0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            check_start_q <= 1'b1;
        end else begin
            wr_pend_q <= addr_valid && i_hwrite;
            if (addr_valid) begin
                wr_addr_q <= addr_lo;
            end
            if (wr_ctrl) begin
                ctrl_q <= i_hwdata[LSFS_CTRL_W-1:0];
            end
            if (wr_num) begin
                num_q <= i_hwdata;
            end
            if (wr_den) begin
                den_q <= i_hwdata;
            end
            if (wr_filt) begin
                filt_q <= i_hwdata[LSFS_FILT_W-1:0];
            end
            if (wr_res) begin
                res_q <= i_hwdata;
            end
            if (wr_irq_mask) begin
                irq_mask_q <= i_hwdata[LSFS_IRQ_W-1:0];
            end
            // any write to gear settings re-runs the limit check
            // a write that meets a running check waits until the checker is idle,
            // else the alarm would follow stale gear terms
            check_start_q <= (check_start_q && chk_busy) ||
                wr_ctrl || wr_num || wr_den || wr_res;
        end
    end

    // ----------------------------------------------------------------
    // gear limit check
    // ----------------------------------------------------------------
    logic gear_alarm_q;

    lsfs_gcd_check #(
        .W(32)
    ) u_gcd (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_start(check_start_q),
        .i_a(num_q),
        .i_b(den_q),
        .o_busy(chk_busy),
        .o_done(chk_done),
        .o_coprime(chk_coprime)
    );

    wire check_skip = abz_rotary && (res_q == LSFS_RES_RESET); // R2
    // a reduced term stays above the limit only when gcd is one: any
    // common factor of two or more halves a 32-bit value below 2^31
    wire gear_over = chk_coprime && ((num_q > LSFS_GEAR_LIMIT) || (den_q > LSFS_GEAR_LIMIT));
    wire gear_bad = !check_skip && (gear_over || (den_q == 32'h0000_0000)); // R1 R2

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            gear_alarm_q <= 1'b0;
        end else if (chk_done) begin
            gear_alarm_q <= gear_bad; // R1
        end
    end

    // ----------------------------------------------------------------
    // mode selection and encoder type
    // ----------------------------------------------------------------
    wire mode_dual = (filt_q >= LSFS_FILT_DUAL_MIN) && (filt_q <= LSFS_FILT_DUAL_MAX); // R3
    wire mode_full = (filt_q == LSFS_FILT_FULL); // R3
    wire filt_bad = !mode_dual && !mode_full;
    wire alarm_now = gear_alarm_q || filt_bad;
    wire rotary_now = (res_q != LSFS_RES_RESET); // R7

    // ----------------------------------------------------------------
    // counters and gear scaler
    // ----------------------------------------------------------------
    logic [31:0] motor_cum_q;
    logic [31:0] scaled_cum_q;
    logic [31:0] load_cum_q;
    logic [31:0] load_pos_q;
    logic signed [33:0] rem_q;

    wire signed [33:0] num_s = {2'b00, num_q};
    wire signed [33:0] den_s = {2'b00, den_q};
    wire signed [33:0] rem_add = motor_edge ? (motor_ccw ? num_s : -num_s) : 34'sh0;
    wire rem_up = (den_q != 32'h0000_0000) && (rem_q >= den_s);
    wire rem_dn = (den_q != 32'h0000_0000) && (rem_q <= -den_s);
    wire signed [33:0] rem_sub = rem_up ? den_s : rem_dn ? -den_s : 34'sh0;
    wire load_up = load_fwd ^ polarity_inv; // R12
    wire [31:0] load_delta = load_up ? 32'h0000_0001 : 32'hFFFF_FFFF;

    // one unit of quotient per clock: limitation is that num/den per
    // motor pulse must stay below the pulse spacing in clocks
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            motor_cum_q <= 32'h0000_0000;
            scaled_cum_q <= 32'h0000_0000;
            load_cum_q <= 32'h0000_0000;
            load_pos_q <= 32'h0000_0000;
            rem_q <= 34'sh0;
        end else begin
            if (motor_edge) begin
                motor_cum_q <= motor_ccw ? motor_cum_q + 32'h1 : motor_cum_q - 32'h1; // R11
            end
            rem_q <= rem_q + rem_add - rem_sub; // R14
            if (rem_up) begin
                scaled_cum_q <= scaled_cum_q + 32'h1; // R10
            end else if (rem_dn) begin
                scaled_cum_q <= scaled_cum_q - 32'h1; // R10
            end
            if (load_step) begin
                load_cum_q <= load_cum_q + load_delta; // R9
            end
            if (z_edge) begin
                load_pos_q <= 32'h0000_0000; // R8
            end else if (load_step) begin
                load_pos_q <= load_pos_q + load_delta;
            end
        end
    end

    // ----------------------------------------------------------------
    // dual feedback blend
    // ----------------------------------------------------------------
    wire signed [31:0] fb_diff = $signed(load_cum_q - scaled_cum_q);
    wire [22:0] blend_w = 23'(filt_q * LSFS_BLEND_RECIP);
    wire signed [55:0] blend_p = fb_diff * $signed({1'b0, blend_w});
    wire [31:0] blend_c = 32'(blend_p >>> LSFS_BLEND_SHIFT);
    wire [31:0] fb_next = mode_full ? load_cum_q : scaled_cum_q + blend_c; // R5

    // ----------------------------------------------------------------
    // interrupts and outputs
    // ----------------------------------------------------------------
    logic alarm_q;
    logic full_q;
    logic dual_q;
    logic rotary_q;
    logic irq_q;
    logic [31:0] fb_q;

    wire [2:0] irq_set = {chk_done, z_edge, alarm_now && !alarm_q};
    wire [2:0] irq_clr = wr_irq_stat ? i_hwdata[LSFS_IRQ_W-1:0] : 3'h0;
    wire [4:0] status = {chk_busy || check_start_q, rotary_q, dual_q, full_q, alarm_q};

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            irq_stat_q <= 3'h0;
            alarm_q <= 1'b0;
            full_q <= 1'b0;
            dual_q <= 1'b0;
            rotary_q <= 1'b0;
            irq_q <= 1'b0;
            fb_q <= 32'h0000_0000;
        end else begin
            // a new event wins over a clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            alarm_q <= alarm_now;
            full_q <= mode_full; // R3
            dual_q <= mode_dual; // R3
            rotary_q <= rotary_now; // R7
            irq_q <= |(irq_stat_q & irq_mask_q);
            fb_q <= fb_next;
        end
    end

    // ----------------------------------------------------------------
    // bus read path
    // ----------------------------------------------------------------
    wire [31:0] rd_mux =
        (addr_lo == LSFS_CTRL_OFS) ? {30'h0, ctrl_q} :
        (addr_lo == LSFS_NUM_OFS) ? num_q :
        (addr_lo == LSFS_DEN_OFS) ? den_q :
        (addr_lo == LSFS_FILT_OFS) ? {19'h0, filt_q} :
        (addr_lo == LSFS_RES_OFS) ? res_q :
        (addr_lo == LSFS_STAT_OFS) ? {27'h0, status} :
        (addr_lo == LSFS_IRQ_STAT_OFS) ? {29'h0, irq_stat_q} :
        (addr_lo == LSFS_IRQ_MASK_OFS) ? {29'h0, irq_mask_q} :
        (addr_lo == LSFS_MOTOR_CUM_OFS) ? motor_cum_q :
        (addr_lo == LSFS_SCALED_CUM_OFS) ? scaled_cum_q :
        (addr_lo == LSFS_LOAD_CUM_OFS) ? load_cum_q :
        (addr_lo == LSFS_LOAD_POS_OFS) ? load_pos_q : 32'h0000_0000;
    wire upper_zero = (i_haddr[31:8] == 24'h000000);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
        end else begin
            hreadyout_q <= 1'b1;
            if (addr_valid && !i_hwrite) begin
                hrdata_q <= upper_zero ? rd_mux : 32'h0000_0000;
            end
        end
    end

    assign o_hreadyout = hreadyout_q;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_q;
    assign o_fb_position = fb_q;
    assign o_fully_closed = full_q;
    assign o_dual_feedback = dual_q;
    assign o_load_rotary = rotary_q;
    assign o_param_alarm = alarm_q;
    assign o_irq = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    chk_filter_reset: assert property ( // R4
        @(posedge i_ref_clk) disable iff (1'b0) i_srst |=> (filt_q == LSFS_FILT_RESET))
        else $error("filter setting not ten after reset");
    chk_mode_select: assert property ( // R3
        (!i_srst && !wr_filt) ##1 !wr_filt |-> (o_fully_closed == (filt_q == 13'h1194))
            && (o_dual_feedback == (filt_q >= 13'h0001 && filt_q <= 13'h1193)))
        else $error("mode does not follow filter setting");
    chk_zero_clear: assert property ( // R8
        z_edge |=> (load_pos_q == 32'h0000_0000))
        else $error("load position not cleared at mark");
    chk_load_polarity: assert property ( // R12
        (load_step && (load_fwd == polarity_inv)) |=> (load_cum_q == $past(load_cum_q) - 32'h1))
        else $error("load count direction wrong");
    chk_load_count: assert property ( // R9
        (load_step && (load_fwd != polarity_inv)) |=> (load_cum_q == $past(load_cum_q) + 32'h1))
        else $error("load count did not advance");
    chk_motor_count: assert property ( // R11
        (motor_edge && motor_ccw) |=> (motor_cum_q == $past(motor_cum_q) + 32'h1))
        else $error("motor count did not advance");
    chk_rotary_flag: assert property ( // R7
        $changed(res_q) |=> (o_load_rotary == (res_q != 32'h0)))
        else $error("encoder type flag wrong");
    chk_gear_skip: assert property ( // R2
        (chk_done && abz_rotary && res_q == 32'h0) |=> !gear_alarm_q)
        else $error("gear check not skipped");
    chk_gear_limit: assert property ( // R1
        (chk_done && !check_skip && chk_coprime && num_q[31]) |=> gear_alarm_q ##1 o_param_alarm)
        else $error("gear limit alarm missing");
    chk_scale_step: assert property ( // R14
        rem_up |=> (scaled_cum_q == $past(scaled_cum_q) + 32'h1))
        else $error("scaled count missed a carry");

endmodule

// ==== tb/lsfs_enc_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// motor and load encoder model
// ----------------------------------------------------------------
module lsfs_enc_model (
    // clock
    input wire logic i_ref_clk,
    // bench commands
    input wire logic i_mstep,
    input wire logic i_lstep,
    input wire logic i_up,
    input wire logic i_z,
    // encoder pins
    output logic o_step,
    output logic o_dir,
    output logic o_a,
    output logic o_b,
    output logic o_z
);
    logic [1:0] ph_q = 2'h0;

    // gray phase: only one of a/b changes per count, a leads b going up
    assign o_a = ph_q[1] ^ ph_q[0];
    assign o_b = ph_q[1];

    initial begin
        o_step = 1'b0;
        o_dir = 1'b1;
        o_z = 1'b0;
    end

    always @(posedge i_ref_clk) begin
        o_step <= i_mstep;
        o_dir <= i_up;
        o_z <= i_z;
        if (i_lstep) begin
            ph_q <= i_up ? ph_q + 2'h1 : ph_q - 2'h1;
        end
    end
endmodule

// ==== tb/tb_lsfs_feedback.sv ====
`timescale 1ns/1ps
module tb_lsfs_feedback
    import lsfs_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, step, dir, a, b, z, fc, dual, rot, alarm, irq;
    logic [31:0] hrdata, fbp, rdata, e;
    logic mstep = 1'b0;
    logic lstep = 1'b0;
    logic up = 1'b1;
    logic zc = 1'b0;
    logic [31:0] base [3];
    logic [31:0] fv [4] = '{32'h1, 32'h1193, 32'h1194, 32'h0};
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h40};
    logic [31:0] rv [7] = '{32'h0, 32'h1, 32'h1, 32'hA, 32'h0, 32'h0, 32'h0};
    int n_mismatch = 0;
    int checked = 0;

    always #2 clk = ~clk;

    lsfs_feedback lsfs_feedback_inst (.i_ref_clk(clk), .i_srst(srst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_motor_step(step), .i_motor_dir(dir), .i_load_a(a),
        .i_load_b(b), .i_load_z(z), .o_fb_position(fbp), .o_fully_closed(fc),
        .o_dual_feedback(dual), .o_load_rotary(rot), .o_param_alarm(alarm), .o_irq(irq));

    lsfs_enc_model lsfs_enc_model_inst (.i_ref_clk(clk), .i_mstep(mstep), .i_lstep(lstep),
        .i_up(up), .i_z(zc), .o_step(step), .o_dir(dir), .o_a(a), .o_b(b), .o_z(z));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // single word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdata = hrdata;
    endtask

    task automatic rc(input logic [7:0] ad, input logic [31:0] x);
        bus(ad, 1'b0, 32'h0);
        chk(rdata, x);
    endtask

    // gear check starts late, so give it a few edges before polling busy
    task automatic settle();
        int n;
        repeat (4) @(posedge clk);
        n = 0;
        do begin
            bus(LSFS_STAT_OFS, 1'b0, 32'h0);
            n = n + 1;
        end while (rdata[LSFS_ST_BUSY_BIT] !== 1'b0 && n < 300);
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse(input logic m, input logic l, input logic u, input int n);
        up <= u;
        repeat (4) @(posedge clk);
        repeat (n) begin
            mstep <= m;
            lstep <= l;
            @(posedge clk);
            mstep <= 1'b0;
            lstep <= 1'b0;
            repeat (7) @(posedge clk);
        end
    endtask

    task automatic snap();
        for (int i = 0; i < 3; i++) begin
            bus(LSFS_MOTOR_CUM_OFS + 8'(4 * i), 1'b0, 32'h0);
            base[i] = rdata;
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (50000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        settle();
        bus(8'h40, 1'b1, 32'h5);
        for (int i = 0; i < 7; i++) begin
            rc(ra[i], rv[i]);
        end
        chk({31'h0, dual}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            bus(LSFS_FILT_OFS, 1'b1, fv[i]);
            repeat (4) @(posedge clk);
            e = {29'h0, fv[i] != 32'h0 && fv[i] < 32'h1194, fv[i] == 32'h1194, fv[i] == 32'h0};
            rc(LSFS_STAT_OFS, e);
            chk({29'h0, dual, fc, alarm}, e);
        end
        bus(LSFS_FILT_OFS, 1'b1, 32'hA);
        $display("test filter modes done");
        bus(LSFS_RES_OFS, 1'b1, 32'h3E8);
        settle();
        chk({31'h0, rot}, 32'h1);
        bus(LSFS_RES_OFS, 1'b1, 32'h0);
        settle();
        chk({31'h0, rot}, 32'h0);
        $display("test encoder type done");
        bus(LSFS_IRQ_STAT_OFS, 1'b1, 32'h7);
        bus(LSFS_IRQ_MASK_OFS, 1'b1, 32'h1);
        bus(LSFS_NUM_OFS, 1'b1, 32'h8000_0000);
        settle();
        chk({30'h0, alarm, irq}, 32'h3);
        bus(LSFS_IRQ_STAT_OFS, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        chk({30'h0, alarm, irq}, 32'h2);
        bus(LSFS_CTRL_OFS, 1'b1, 32'h2);
        settle();
        chk({31'h0, alarm}, 32'h0);
        bus(LSFS_CTRL_OFS, 1'b1, 32'h0);
        bus(LSFS_DEN_OFS, 1'b1, 32'h2);
        settle();
        chk({31'h0, alarm}, 32'h0);
        $display("test gear alarm done");
        bus(LSFS_NUM_OFS, 1'b1, 32'h3);
        settle();
        snap();
        pulse(1'b1, 1'b0, 1'b1, 4);
        pulse(1'b0, 1'b1, 1'b1, 6);
        rc(LSFS_MOTOR_CUM_OFS, base[0] + 32'h4);
        rc(LSFS_SCALED_CUM_OFS, base[1] + 32'h6);
        rc(LSFS_LOAD_CUM_OFS, base[2] + 32'h6);
        pulse(1'b1, 1'b0, 1'b0, 2);
        rc(LSFS_MOTOR_CUM_OFS, base[0] + 32'h2);
        rc(LSFS_SCALED_CUM_OFS, base[1] + 32'h3);
        bus(LSFS_CTRL_OFS, 1'b1, 32'h1);
        settle();
        pulse(1'b0, 1'b1, 1'b1, 2);
        rc(LSFS_LOAD_CUM_OFS, base[2] + 32'h4);
        bus(LSFS_FILT_OFS, 1'b1, 32'h1);
        repeat (4) @(posedge clk);
        chk(fbp, base[1] + 32'h3);
        bus(LSFS_FILT_OFS, 1'b1, 32'h1194);
        repeat (4) @(posedge clk);
        chk(fbp, base[2] + 32'h4);
        bus(LSFS_FILT_OFS, 1'b1, 32'hA);
        $display("test counting done");
        bus(LSFS_IRQ_STAT_OFS, 1'b1, 32'h7);
        zc <= 1'b1;
        repeat (6) @(posedge clk);
        zc <= 1'b0;
        repeat (6) @(posedge clk);
        rc(LSFS_LOAD_POS_OFS, 32'h0);
        rc(LSFS_IRQ_STAT_OFS, 32'h2);
        bus(LSFS_IRQ_STAT_OFS, 1'b1, 32'h2);
        rc(LSFS_IRQ_STAT_OFS, 32'h0);
        $display("test reference mark done");
        report_and_stop();
    end
endmodule
